// *** src/ciex_pkg.sv ***
// Package with the constants, opcodes and carriers of the execute subset.
`default_nettype none

package ciex_pkg;

  // ==========================================================================
  // Widths and reset values.
  // ==========================================================================
  localparam int unsigned DATA_W   = 8;     // Data byte width.
  localparam int unsigned FADDR_W  = 7;     // File register address width.
  localparam int unsigned PC_W     = 10;    // Default program counter width.
  localparam logic [7:0]  ACC_RST  = 8'h00; // Accumulator after reset.
  localparam logic [7:0]  WDT_CLR  = 8'h00; // Watchdog count after power down.
  localparam logic        DEST_ACC = 1'h0;  // Select value routing to accumulator.
  localparam logic        DEST_REG = 1'h1;  // Select value routing back to file.
  localparam logic        FLAG_CLR = 1'h0;  // Cleared flag level.
  localparam logic        FLAG_SET = 1'h1;  // Set flag level.

  // ==========================================================================
  // Opcodes of the executed subset; other codes are treated as idle.
  // ==========================================================================
  typedef enum logic [2:0] {
    CIEX_IDLE_OP       = 3'h0,
    CIEX_SUB_EXIT_OP   = 3'h1,
    CIEX_ROT_LEFT_OP   = 3'h2,
    CIEX_ROT_RIGHT_OP  = 3'h3,
    CIEX_LIT_MINUS_OP  = 3'h4,
    CIEX_FILE_MINUS_OP = 3'h5,
    CIEX_NIB_EXCH_OP   = 3'h6,
    CIEX_PWR_DOWN_OP   = 3'h7
  } ciex_op_t;

  // Decoded instruction as delivered by the fetch stage.
  typedef struct packed {
    ciex_op_t             op;      // Operation.
    logic [FADDR_W-1:0]   faddr;   // File register address, 0 to 127.
    logic                 dest;    // Destination select bit.
    logic [DATA_W-1:0]    literal; // Literal operand, 0 to 255.
  } ciex_instr_t;

  // Status flags; expiry and powered-down flags are active low.
  typedef struct packed {
    logic watchdog_expiry_flag;
    logic powered_down_flag;
    logic all_null;    // Result was zero.
    logic half_nibble; // No borrow out of bit 3.
    logic ripple_out;  // Carry; no borrow out of bit 7.
  } ciex_status_t;

  // Status after reset: both active-low flags read 1.
  localparam ciex_status_t STATUS_RST = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0};

  // Execution states.
  typedef enum logic [1:0] {
    CIEX_ST_RUN   = 2'h0,
    CIEX_ST_RET2  = 2'h1,
    CIEX_ST_SLEEP = 2'h2
  } ciex_state_t;

endpackage

`default_nettype wire

// *** src/ciex_core.sv ***
// Execute stage of the 8-bit core for the subset of operations below.
// Functional notes
// - Subroutine exit pops stack, loads head, two cycles.
// - Rotate left through ripple flag only.
// - Rotate right through ripple flag only.
// - Select 0 writes accumulator, 1 writes file.
// - Literal minus accumulator updates three flags.
// - File minus accumulator, routed, three flags.
// - Power down pulses watchdog clear output, one cycle.
// - Power down clears powered-down, sets expiry flag.
// - Power down halts execution until wake.
// - Nibble exchange swaps halves, no flags.
// - Nibble exchange stores to file when select 1.
`timescale 1ns/1ps
`default_nettype none

module ciex_core #(
  parameter int unsigned PC_WIDTH = ciex_pkg::PC_W  // Program counter width.
) (
  // Clock and reset.
  input  wire logic                         clk_i,
  input  wire logic                         sys_rst_i,
  // Instruction from the fetch stage.
  input  wire logic                         instr_valid_i,
  input  wire ciex_pkg::ciex_instr_t        instr_i,
  output logic                              instr_ready_o,
  // Hardware stack.
  input  wire logic [PC_WIDTH-1:0]          stack_head_entry_i,
  output logic                              stack_pop_o,
  // Watchdog and power control.
  output logic                              watchdog_clear_o,
  input  wire logic                         wake_i,
  output logic                              asleep_o,
  // Observed state.
  output logic [PC_WIDTH-1:0]               program_counter_o,
  output logic [ciex_pkg::DATA_W-1:0]       acc_o,
  output ciex_pkg::ciex_status_t            status_o,
  input  wire logic [ciex_pkg::FADDR_W-1:0] peek_addr_i,
  output logic [ciex_pkg::DATA_W-1:0]       peek_data_o
);

  // ==========================================================================
  // Storage.
  // ==========================================================================
  localparam int unsigned NFILE = 2 ** ciex_pkg::FADDR_W; // File register count.

  logic [ciex_pkg::DATA_W-1:0] file_mem [NFILE];  // File registers, cleared by reset.
  ciex_pkg::ciex_state_t       state_q, state_d;  // Execution state.
  logic [PC_WIDTH-1:0]         pc_q, pc_d;        // Program counter.
  logic [ciex_pkg::DATA_W-1:0] acc_q, acc_d;      // Accumulator.
  ciex_pkg::ciex_status_t      stat_q, stat_d;    // Status flags.
  logic                        wdclr_q, wdclr_d;  // Watchdog clear pulse.
  logic [ciex_pkg::DATA_W-1:0] peek_q;            // Registered peek data.
  logic                        fwe;               // File write enable.
  logic [ciex_pkg::DATA_W-1:0] result;            // Result to route.
  logic [ciex_pkg::DATA_W-1:0] fval;              // Addressed file value.
  logic                        take;              // Instruction accepted.

  // Subtraction helper: a minus b with no-borrow flags.
  function automatic logic [ciex_pkg::DATA_W+1:0] sub_flags(
    input logic [ciex_pkg::DATA_W-1:0] a,
    input logic [ciex_pkg::DATA_W-1:0] b
  );
    logic [ciex_pkg::DATA_W:0] diff;
    logic                      half;
    diff = {1'h0, a} - {1'h0, b};
    half = (a[3:0] >= b[3:0]);
    // Carry is the inverse of borrow, as two's complement subtraction yields.
    sub_flags = {~diff[ciex_pkg::DATA_W], half, diff[ciex_pkg::DATA_W-1:0]};
  endfunction

  assign fval          = file_mem[instr_i.faddr];
  assign instr_ready_o = (state_q == ciex_pkg::CIEX_ST_RUN);
  assign take          = instr_valid_i && instr_ready_o;

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  // One instruction per cycle in RUN; the exit op spends a second cycle.
  always_comb
  begin
    logic [ciex_pkg::DATA_W+1:0] sf;
    sf           = '0;
    state_d      = state_q;
    pc_d         = pc_q;
    acc_d        = acc_q;
    stat_d       = stat_q;
    wdclr_d      = 1'h0;
    fwe          = 1'h0;
    result       = fval;
    stack_pop_o  = 1'h0;
    unique case (state_q)
      ciex_pkg::CIEX_ST_RUN:
      begin
        if (take)
        begin
          pc_d = pc_q + PC_WIDTH'(1);
          unique case (instr_i.op)
            ciex_pkg::CIEX_SUB_EXIT_OP:
            begin
              // Pop now, load the head entry, burn one extra cycle; flags kept.
              stack_pop_o = 1'h1;
              pc_d        = stack_head_entry_i;
              state_d     = ciex_pkg::CIEX_ST_RET2;
            end
            ciex_pkg::CIEX_ROT_LEFT_OP:
            begin
              result            = {fval[6:0], stat_q.ripple_out};
              stat_d.ripple_out = fval[7];
            end
            ciex_pkg::CIEX_ROT_RIGHT_OP:
            begin
              result            = {stat_q.ripple_out, fval[7:1]};
              stat_d.ripple_out = fval[0];
            end
            ciex_pkg::CIEX_LIT_MINUS_OP:
            begin
              sf                 = sub_flags(instr_i.literal, acc_q);
              acc_d              = sf[ciex_pkg::DATA_W-1:0];
              stat_d.ripple_out  = sf[ciex_pkg::DATA_W+1];
              stat_d.half_nibble = sf[ciex_pkg::DATA_W];
              stat_d.all_null    = (sf[ciex_pkg::DATA_W-1:0] == '0);
            end
            ciex_pkg::CIEX_FILE_MINUS_OP:
            begin
              sf                 = sub_flags(fval, acc_q);
              result             = sf[ciex_pkg::DATA_W-1:0];
              stat_d.ripple_out  = sf[ciex_pkg::DATA_W+1];
              stat_d.half_nibble = sf[ciex_pkg::DATA_W];
              stat_d.all_null    = (result == '0);
            end
            ciex_pkg::CIEX_NIB_EXCH_OP:
            begin
              result = {fval[3:0], fval[7:4]};
            end
            ciex_pkg::CIEX_PWR_DOWN_OP:
            begin
              wdclr_d                     = 1'h1;
              stat_d.powered_down_flag    = ciex_pkg::FLAG_CLR;
              stat_d.watchdog_expiry_flag = ciex_pkg::FLAG_SET;
              state_d                     = ciex_pkg::CIEX_ST_SLEEP;
            end
            default:
            begin
              // Idle op: the counter advance above is its only effect.
              result = fval;
            end
          endcase
          // Route file-result ops by the destination select bit.
          if (instr_i.op inside {ciex_pkg::CIEX_ROT_LEFT_OP, ciex_pkg::CIEX_ROT_RIGHT_OP,
                                 ciex_pkg::CIEX_FILE_MINUS_OP, ciex_pkg::CIEX_NIB_EXCH_OP})
          begin
            if (instr_i.dest == ciex_pkg::DEST_REG)
            begin
              fwe = 1'h1;
            end
            else
            begin
              acc_d = result;
            end
          end
        end
      end
      ciex_pkg::CIEX_ST_RET2:
      begin
        // Second cycle of the exit op; nothing else happens.
        state_d = ciex_pkg::CIEX_ST_RUN;
      end
      ciex_pkg::CIEX_ST_SLEEP:
      begin
        // Execution stays stopped until an outside wake event.
        if (wake_i)
        begin
          state_d = ciex_pkg::CIEX_ST_RUN;
        end
      end
      default:
      begin
        state_d = ciex_pkg::CIEX_ST_RUN;
      end
    endcase
  end

  // ==========================================================================
  // State registers.
  // ==========================================================================
  // Synchronous reset of all control state; the file array holds data only.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ciex_pkg::CIEX_ST_RUN;
      pc_q    <= '0;
      acc_q   <= ciex_pkg::ACC_RST;
      stat_q  <= ciex_pkg::STATUS_RST;
      wdclr_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      pc_q    <= pc_d;
      acc_q   <= acc_d;
      stat_q  <= stat_d;
      wdclr_q <= wdclr_d;
    end
  end

  // File write port and registered peek port. Reset clears the whole file, at the
  // cost of a wide reset, so that no operation can ever work on an unknown byte.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int unsigned i = 0; i < NFILE; i++)
      begin
        file_mem[i] <= '0;
      end
    end
    else if (fwe)
    begin
      file_mem[instr_i.faddr] <= result;
    end
    peek_q <= file_mem[peek_addr_i];
  end

  assign program_counter_o = pc_q;
  assign acc_o             = acc_q;
  assign status_o          = stat_q;
  assign watchdog_clear_o  = wdclr_q;
  assign asleep_o          = (state_q == ciex_pkg::CIEX_ST_SLEEP);
  assign peek_data_o       = peek_q;

endmodule // ciex_core

`default_nettype wire

// *** verif/ciex_core_asserts.sv ***
// Checker of the execute subset core ports.
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Port checks; file contents are not visible here.
module ciex_core_asserts #(parameter int unsigned PC_WIDTH = 10) (
  // Clock, reset and handshake.
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   instr_valid_i,
  input wire ciex_pkg::ciex_instr_t  instr_i,
  input wire logic                   instr_ready_o,
  // Stack, power and state.
  input wire logic [PC_WIDTH-1:0]    stack_head_entry_i,
  input wire logic                   stack_pop_o,
  input wire logic                   watchdog_clear_o,
  input wire logic                   asleep_o,
  input wire logic [PC_WIDTH-1:0]    program_counter_o,
  input wire logic [7:0]             acc_o,
  input wire ciex_pkg::ciex_status_t status_o
);
  logic               tk; // Request taken at this edge.
  ciex_pkg::ciex_op_t op; // Opcode on offer.
  assign tk = instr_valid_i && instr_ready_o;
  assign op = instr_i.op;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==================================================
  // Assertions.
  exit_load_a:
    assert property (tk && op == ciex_pkg::CIEX_SUB_EXIT_OP |-> stack_pop_o ##1
      (program_counter_o == $past(stack_head_entry_i) && !instr_ready_o
      && status_o == $past(status_o)) ##1 instr_ready_o) else $error("bad exit");
  pop_cause_a:
    assert property (stack_pop_o |-> tk && op == ciex_pkg::CIEX_SUB_EXIT_OP)
      else $error("stray pop");
  rot_flags_a:
    assert property (tk && op inside {ciex_pkg::CIEX_ROT_LEFT_OP, ciex_pkg::CIEX_ROT_RIGHT_OP}
      |=> status_o[4:1] == $past(status_o[4:1])) else $error("rotate flags");
  lit_minus_a:
    assert property (tk && op == ciex_pkg::CIEX_LIT_MINUS_OP |=>
      acc_o == 8'($past(instr_i.literal) - $past(acc_o))
      && status_o.ripple_out == ($past(instr_i.literal) >= $past(acc_o)))
      else $error("literal minus");
  dest_file_a:
    assert property (tk && instr_i.dest
      && op inside {ciex_pkg::CIEX_FILE_MINUS_OP, ciex_pkg::CIEX_NIB_EXCH_OP}
      |=> $stable(acc_o)) else $error("acc written");
  nib_flags_a:
    assert property (tk && op == ciex_pkg::CIEX_NIB_EXCH_OP |=> $stable(status_o))
      else $error("exchange flags");
  pd_entry_a:
    assert property (tk && op == ciex_pkg::CIEX_PWR_DOWN_OP |=> watchdog_clear_o && asleep_o
      && !status_o.powered_down_flag && status_o.watchdog_expiry_flag
      && status_o[2:0] == $past(status_o[2:0])) else $error("power down");
  clr_pulse_a:
    assert property (watchdog_clear_o |=> !watchdog_clear_o) else $error("clear pulse");
  halt_a:
    assert property (asleep_o |-> !instr_ready_o ##1 $stable(program_counter_o))
      else $error("runs asleep");
  idle_a:
    assert property (tk && op == ciex_pkg::CIEX_IDLE_OP |=> $stable(acc_o) && $stable(status_o)
      && program_counter_o == PC_WIDTH'($past(program_counter_o) + 1)) else $error("idle");
  cover property (tk && op == ciex_pkg::CIEX_SUB_EXIT_OP);
  cover property (tk && op == ciex_pkg::CIEX_PWR_DOWN_OP);
  cover property (asleep_o ##1 !asleep_o);
endmodule // ciex_core_asserts
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the execute subset core.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==================================================
  // Stimulus, outputs and the bench's own model.
  localparam int unsigned PC_WIDTH = 10;
  logic                   clk_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0, wake_i = 1'b0;
  ciex_pkg::ciex_instr_t  instr_i = '0;
  logic [PC_WIDTH-1:0]    head_i = 10'h2a5, pc_o, exp_pc;
  logic [6:0]             peek_i = 7'h15; // Same file address as every operation.
  logic [7:0]             acc_o, peek_o, exp_acc, exp_file; // exp_file models address 15h.
  ciex_pkg::ciex_status_t st_o, exp_st;
  logic                   ready_o, pop_o, wdc_o, asleep_o;
  int                     mismatches = 0, num_checks = 0;
  ciex_core #(.PC_WIDTH(PC_WIDTH)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(ready_o),
    .stack_head_entry_i(head_i), .stack_pop_o(pop_o), .watchdog_clear_o(wdc_o),
    .wake_i(wake_i), .asleep_o(asleep_o), .program_counter_o(pc_o), .acc_o(acc_o),
    .status_o(st_o), .peek_addr_i(peek_i), .peek_data_o(peek_o));
  initial forever #2.5 clk_i = ~clk_i;
  // One compare task per kind of result: flag bit, byte and program counter.
  task automatic chk_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pc(input logic [PC_WIDTH-1:0] got, input logic [PC_WIDTH-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_st();
    for (int b = 0; b < 5; b++)
      chk_b(st_o[b], exp_st[b]);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Offers one operation; valid stays up so callers may chain them.
  task automatic run(input ciex_pkg::ciex_op_t op, input logic d, input logic [7:0] k);
    instr_i = '{op, 7'h15, d, k};
    instr_valid_i = 1'b1;
    @(negedge clk_i);
    exp_pc = exp_pc + 1'b1;
  endtask
  task automatic t_lit();
    logic [7:0] ks [6] = '{8'h05, 8'h03, 8'hfe, 8'h10, 8'h2f, 8'h20};
    foreach (ks[i])
    begin
      run(ciex_pkg::CIEX_LIT_MINUS_OP, 1'b0, ks[i]);
      exp_st.ripple_out = ks[i] >= exp_acc;
      exp_st.half_nibble = ks[i][3:0] >= exp_acc[3:0];
      exp_acc = ks[i] - exp_acc;
      exp_st.all_null = exp_acc == 8'h00;
      chk_byte(acc_o, exp_acc);
      chk_st();
      chk_pc(pc_o, exp_pc);
    end
    instr_valid_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic t_exit();
    instr_i.op = ciex_pkg::CIEX_SUB_EXIT_OP;
    instr_valid_i = 1'b1;
    #1;
    chk_b(pop_o, 1'b1);
    @(negedge clk_i);
    exp_pc = head_i;
    chk_pc(pc_o, exp_pc);
    chk_b(ready_o, 1'b0);
    chk_b(pop_o, 1'b0);
    chk_st();
    instr_i.op = ciex_pkg::CIEX_IDLE_OP;
    @(negedge clk_i);
    chk_pc(pc_o, exp_pc);
    chk_b(ready_o, 1'b1);
    run(ciex_pkg::CIEX_IDLE_OP, 1'b0, 8'h00);
    chk_pc(pc_o, exp_pc);
    chk_byte(acc_o, exp_acc);
    chk_byte(peek_o, exp_file);
    chk_st();
    instr_valid_i = 1'b0;
    @(negedge clk_i);
  endtask
  // The bench keeps its own copy of the file byte; the first op seeds the accumulator.
  task automatic t_file();
    ciex_pkg::ciex_op_t ops [7] = '{ciex_pkg::CIEX_LIT_MINUS_OP, ciex_pkg::CIEX_FILE_MINUS_OP,
      ciex_pkg::CIEX_ROT_LEFT_OP, ciex_pkg::CIEX_ROT_RIGHT_OP, ciex_pkg::CIEX_NIB_EXCH_OP,
      ciex_pkg::CIEX_ROT_RIGHT_OP, ciex_pkg::CIEX_FILE_MINUS_OP};
    logic       ds [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [7:0] a, res;
    foreach (ops[i])
    begin
      run(ops[i], ds[i], 8'h5c);
      instr_valid_i = 1'b0;
      case (ops[i])
        ciex_pkg::CIEX_ROT_LEFT_OP: {exp_st.ripple_out, res} = {exp_file, exp_st.ripple_out};
        ciex_pkg::CIEX_ROT_RIGHT_OP: {res, exp_st.ripple_out} = {exp_st.ripple_out, exp_file};
        ciex_pkg::CIEX_NIB_EXCH_OP: res = {exp_file[3:0], exp_file[7:4]};
        default:
        begin
          a = (ops[i] == ciex_pkg::CIEX_LIT_MINUS_OP) ? 8'h5c : exp_file;
          res = a - exp_acc;
          exp_st.ripple_out = a >= exp_acc;
          exp_st.half_nibble = a[3:0] >= exp_acc[3:0];
          exp_st.all_null = res == 8'h00;
        end
      endcase
      if (ds[i])
        exp_file = res;
      else
        exp_acc = res;
      chk_byte(acc_o, exp_acc);
      chk_st();
      chk_pc(pc_o, exp_pc);
      @(negedge clk_i);
      chk_byte(peek_o, exp_file);
    end
  endtask
  task automatic t_sleep();
    int n;
    run(ciex_pkg::CIEX_PWR_DOWN_OP, 1'b0, 8'h00);
    instr_i.op = ciex_pkg::CIEX_IDLE_OP;
    exp_st.powered_down_flag = 1'b0;
    exp_st.watchdog_expiry_flag = 1'b1;
    chk_b(wdc_o, 1'b1);
    chk_st();
    chk_b(asleep_o, 1'b1);
    repeat (3) @(negedge clk_i);
    chk_b(wdc_o, 1'b0);
    chk_b(ready_o, 1'b0);
    chk_pc(pc_o, exp_pc);
    wake_i = 1'b1;
    @(negedge clk_i);
    wake_i = 1'b0;
    for (n = 0; n < 4 && ready_o !== 1'b1; n++)
      @(negedge clk_i);
    chk_b(asleep_o, 1'b0);
    chk_b(ready_o, 1'b1);
    instr_valid_i = 1'b0;
    @(negedge clk_i);
    run(ciex_pkg::CIEX_IDLE_OP, 1'b0, 8'h00);
    instr_valid_i = 1'b0;
    chk_pc(pc_o, exp_pc);
    chk_st();
  endtask
  initial
  begin
    exp_pc = '0;
    exp_acc = 8'h00;
    exp_file = 8'h00;
    exp_st = ciex_pkg::STATUS_RST;
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk_pc(pc_o, exp_pc);
    chk_byte(acc_o, exp_acc);
    chk_byte(peek_o, exp_file);
    chk_st();
    t_lit();
    t_exit();
    t_file();
    t_sleep();
    wrap_up();
  end
  initial
  begin
    #20us;
    mismatches++;
    wrap_up();
  end
endmodule // testbench
bind ciex_core ciex_core_asserts #(.PC_WIDTH(PC_WIDTH)) u_chk (.*);
`default_nettype wire
